// ---- rtl/can_bit_timing_mode_control.v ----
// can bit timing, bit stream, init handshake and low power mode control
`timescale 1ns/1ps
`default_nettype none
`include "can_mode_defines.vh"
module can_bit_timing_mode_control #(
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW = 3
) (
	input wire CORE_CLK_IN,
	input wire ARST_N_IN,
	input wire MODULE_ENABLE_BIT_IN,
	input wire INIT_REQUEST_BIT_IN,
	input wire SLEEP_REQUEST_BIT_IN,
	input wire STOP_IN_WAIT_BIT_IN,
	input wire [1:0] CPU_MODE_IN,
	input wire SPECIAL_MODE_IN,
	input wire LISTEN_ONLY_IN,
	input wire TRIPLE_SAMPLE_IN,
	input wire CFG_WRITE_IN,
	input wire [5:0] CFG_PRESCALE_IN,
	input wire [3:0] CFG_SEGMENT1_FIELD_IN,
	input wire [2:0] CFG_SEGMENT2_FIELD_IN,
	input wire [1:0] CFG_JUMP_WIDTH_FIELD_IN,
	input wire TX_PENDING_IN,
	input wire [7:0] TX_DATA_IN,
	input wire TX_VALID_IN,
	output wire TX_READY_OUT,
	input wire PROTO_DOMINANT_IN,
	input wire BUS_RECEIVE_PIN_IN,
	output wire BUS_TRANSMIT_PIN_OUT,
	output wire [7:0] RX_DATA_OUT,
	output wire RX_VALID_OUT,
	input wire RX_READY_IN,
	output wire MONITOR_BIT_OUT,
	output wire INIT_ACKNOWLEDGE_FLAG_OUT,
	output wire SLEEP_ACKNOWLEDGE_FLAG_OUT,
	output wire INIT_REQUEST_STATE_OUT,
	output wire CONFIG_LOCKED_OUT,
	output wire REGS_RESET_OUT,
	output wire ENGINE_RUN_OUT,
	output wire REG_CLOCK_RUN_OUT,
	output wire POWER_DOWN_OUT,
	output wire [3:0] SEGMENT1_FIELD_OUT,
	output wire [2:0] SEGMENT2_FIELD_OUT,
	output wire [1:0] JUMP_WIDTH_FIELD_OUT,
	output wire SAMPLE_POINT_OUT
);
	localparam SEG_SYNC = 3'b001;
	localparam SEG_ONE = 3'b010;
	localparam SEG_TWO = 3'b100;
	reg [5:0] prescale;
	reg [3:0] seg1_field;
	reg [2:0] seg2_field;
	reg [1:0] sjw_field;
	reg init_req;
	reg init_ack;
	reg sleep_ack;
	reg was_enabled;
	reg [`INIT_SYNC_STAGES-1:0] init_sync;
	reg [2:0] rx_meta;
	reg [2:0] seg;
	reg [5:0] pre_cnt;
	reg [3:0] tq_cnt;
	reg [2:0] samples;
	reg rx_bit;
	reg bus_busy;
	reg [3:0] idle_run;
	reg [7:0] rx_shift;
	reg [2:0] rx_bits;
	reg [7:0] tx_shift;
	reg [2:0] tx_bits;
	reg tx_active;
	reg tx_level;
	reg rx_push;
	wire power_down;
	wire engine_run;
	wire tq_tick;
	wire sample_pt;
	wire rx_level;
	wire majority;
	wire cfg_open;
	wire rx_ready_int;
	wire tx_out_valid;
	wire [7:0] tx_out_data;
	wire tx_take;
	wire in_init;
	// wait with stop bit or cpu stop forces power down
	assign power_down = MODULE_ENABLE_BIT_IN &&
		((CPU_MODE_IN == `CPU_STOP) || ((CPU_MODE_IN == `CPU_WAIT) && STOP_IN_WAIT_BIT_IN));
	assign in_init = init_req && init_ack;
	// clocks gated by enable and power down, engine clock also by sleep and init
	assign engine_run = MODULE_ENABLE_BIT_IN && !power_down && !sleep_ack && !init_req;
	assign REG_CLOCK_RUN_OUT = MODULE_ENABLE_BIT_IN && !power_down;
	assign ENGINE_RUN_OUT = engine_run;
	assign POWER_DOWN_OUT = power_down;
	assign cfg_open = in_init || SPECIAL_MODE_IN;
	assign CONFIG_LOCKED_OUT = !cfg_open;
	assign REGS_RESET_OUT = in_init;
	assign INIT_ACKNOWLEDGE_FLAG_OUT = init_ack;
	assign SLEEP_ACKNOWLEDGE_FLAG_OUT = sleep_ack;
	assign INIT_REQUEST_STATE_OUT = init_req;
	assign SEGMENT1_FIELD_OUT = seg1_field;
	assign SEGMENT2_FIELD_OUT = seg2_field;
	assign JUMP_WIDTH_FIELD_OUT = sjw_field;
	// config writes, field holds length minus one
	always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			prescale <= `PRESCALE_RST;
			seg1_field <= `SEG1_FIELD_RST;
			seg2_field <= `SEG2_FIELD_RST;
			sjw_field <= `SJW_FIELD_RST;
		end else if (CFG_WRITE_IN && cfg_open) begin
			prescale <= CFG_PRESCALE_IN;
			seg1_field <= (CFG_SEGMENT1_FIELD_IN < `SEG1_FIELD_MIN) ?
				`SEG1_FIELD_MIN : CFG_SEGMENT1_FIELD_IN;
			seg2_field <= (CFG_SEGMENT2_FIELD_IN < `SEG2_FIELD_MIN) ?
				`SEG2_FIELD_MIN : CFG_SEGMENT2_FIELD_IN;
			sjw_field <= CFG_JUMP_WIDTH_FIELD_IN;
		end
	end
	// init request handshake across stages
	always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			init_req <= 1'b0;
			was_enabled <= 1'b0;
			init_sync <= {`INIT_SYNC_STAGES{1'b0}};
			init_ack <= 1'b0;
		end else begin
			was_enabled <= MODULE_ENABLE_BIT_IN;
			if (!MODULE_ENABLE_BIT_IN)
				init_req <= 1'b0;
			else if (!was_enabled)
				init_req <= 1'b1;
			else if (INIT_REQUEST_BIT_IN)
				init_req <= 1'b1;
			else if (in_init)
				init_req <= 1'b0;
			if (power_down)
				init_sync <= init_sync;
			else
				init_sync <= {init_sync[`INIT_SYNC_STAGES-2:0], init_req};
			// acknowledge only when every stage agrees
			init_ack <= init_req ? (&init_sync) : (|init_sync);
		end
	end
	// sleep acknowledge after transmit done and bus idle
	always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN)
			sleep_ack <= 1'b0;
		else if (!MODULE_ENABLE_BIT_IN || !SLEEP_REQUEST_BIT_IN)
			sleep_ack <= 1'b0;
		else if (!TX_PENDING_IN && !tx_active && !tx_out_valid && !bus_busy)
			sleep_ack <= 1'b1;
	end
	// receive pin three stage synchroniser
	always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN)
			rx_meta <= 3'h7;
		else
			rx_meta <= {rx_meta[1:0], BUS_RECEIVE_PIN_IN};
	end
	reg rx_stable;
	always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN)
			rx_stable <= 1'b1;
		else if (rx_meta[1] == rx_meta[2])
			rx_stable <= rx_meta[2];
	end
	// dominant bits of listen only node stay internal
	assign rx_level = rx_stable && !(LISTEN_ONLY_IN && PROTO_DOMINANT_IN && engine_run);
	assign MONITOR_BIT_OUT = rx_level;
	assign tq_tick = engine_run && (pre_cnt == prescale);
	assign sample_pt = tq_tick && (seg == SEG_ONE) && (tq_cnt == seg1_field);
	assign SAMPLE_POINT_OUT = sample_pt;
	assign majority = (samples[0] & samples[1]) | (samples[1] & rx_level) | (samples[0] & rx_level);
	// bit timing segments
	always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			pre_cnt <= 6'h00;
			seg <= SEG_SYNC;
			tq_cnt <= 4'h0;
			samples <= 3'h7;
			rx_bit <= 1'b1;
		end else if (!engine_run) begin
			pre_cnt <= 6'h00;
			seg <= SEG_SYNC;
			tq_cnt <= 4'h0;
		end else begin
			pre_cnt <= (pre_cnt == prescale) ? 6'h00 : pre_cnt + 6'h01;
			if (tq_tick) begin
				samples <= {samples[1:0], rx_level};
				case (seg)
				SEG_SYNC: begin
					seg <= SEG_ONE;
					tq_cnt <= 4'h0;
				end
				SEG_ONE: begin
					if (tq_cnt == seg1_field) begin
						seg <= SEG_TWO;
						tq_cnt <= 4'h0;
						rx_bit <= TRIPLE_SAMPLE_IN ? majority : rx_level;
					end else
						tq_cnt <= tq_cnt + 4'h1;
				end
				SEG_TWO: begin
					if (tq_cnt[2:0] == seg2_field) begin
						seg <= SEG_SYNC;
						tq_cnt <= 4'h0;
					end else
						tq_cnt <= tq_cnt + 4'h1;
				end
				default: begin
					seg <= SEG_SYNC;
					tq_cnt <= 4'h0;
				end
				endcase
			end
		end
	end
	// last clock of sync quantum, jump width is stored only
	wire bit_start;
	assign bit_start = tq_tick && (seg == SEG_SYNC);
	// transmit stream, new bit at bit start
	assign tx_take = bit_start && !tx_active && tx_out_valid && !LISTEN_ONLY_IN;
	always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			tx_shift <= 8'hFF;
			tx_bits <= 3'h0;
			tx_active <= 1'b0;
			tx_level <= 1'b1;
		end else if (!engine_run || LISTEN_ONLY_IN) begin
			tx_active <= 1'b0;
			tx_level <= 1'b1;
		end else if (tx_take) begin
			tx_shift <= {tx_out_data[6:0], 1'b1};
			tx_level <= tx_out_data[7];
			tx_bits <= 3'h7;
			tx_active <= 1'b1;
		end else if (bit_start && tx_active) begin
			if (tx_bits == 3'h0) begin
				tx_active <= 1'b0;
				tx_level <= 1'b1;
			end else begin
				tx_level <= tx_shift[7];
				tx_shift <= {tx_shift[6:0], 1'b1};
				tx_bits <= tx_bits - 3'h1;
			end
		end
	end
	assign BUS_TRANSMIT_PIN_OUT = tx_level;
	// receive stream and bus activity tracking
	always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rx_shift <= 8'h00;
			rx_bits <= 3'h0;
			rx_push <= 1'b0;
			bus_busy <= 1'b0;
			idle_run <= 4'h0;
		end else if (!engine_run) begin
			rx_bits <= 3'h0;
			rx_push <= 1'b0;
			if (!MODULE_ENABLE_BIT_IN || init_req || power_down)
				bus_busy <= 1'b0;
			idle_run <= 4'h0;
		end else begin
			if (rx_push && rx_ready_int)
				rx_push <= 1'b0;
			if (sample_pt) begin
				if (!rx_bit)
					bus_busy <= 1'b1;
				if (bus_busy || !rx_bit) begin
					rx_shift <= {rx_shift[6:0], rx_bit};
					rx_bits <= rx_bits + 3'h1;
					if (rx_bits == 3'h7)
						rx_push <= 1'b1;
				end
				idle_run <= rx_bit ? ((idle_run == 4'hA) ? idle_run : idle_run + 4'h1) : 4'h0;
				if (rx_bit && idle_run == 4'h9) begin
					bus_busy <= 1'b0;
					rx_bits <= 3'h0;
				end
			end
		end
	end
	data_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_tx_fifo (
		.clk_in(CORE_CLK_IN),
		.arst_n_in(ARST_N_IN),
		.flush_in(in_init),
		.wr_data_in(TX_DATA_IN),
		.wr_valid_in(TX_VALID_IN),
		.wr_ready_out(TX_READY_OUT),
		.rd_data_out(tx_out_data),
		.rd_valid_out(tx_out_valid),
		.rd_ready_in(tx_take)
	);
	data_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rx_fifo (
		.clk_in(CORE_CLK_IN),
		.arst_n_in(ARST_N_IN),
		.flush_in(in_init),
		.wr_data_in(rx_shift),
		.wr_valid_in(rx_push),
		.wr_ready_out(rx_ready_int),
		.rd_data_out(RX_DATA_OUT),
		.rd_valid_out(RX_VALID_OUT),
		.rd_ready_in(RX_READY_IN)
	);
endmodule // can_bit_timing_mode_control
`default_nettype wire

// ---- inc/can_mode_defines.vh ----
// constants for the can bit timing and mode control block
`ifndef CAN_MODE_DEFINES_VH
`define CAN_MODE_DEFINES_VH
`define SEG1_FIELD_MIN 4'h3
`define SEG1_FIELD_MAX 4'hF
`define SEG2_FIELD_MIN 3'h1
`define SEG2_FIELD_MAX 3'h7
`define SEG1_FIELD_RST 4'h3
`define SEG2_FIELD_RST 3'h1
`define SJW_FIELD_RST 2'h0
`define PRESCALE_RST 6'h00
`define CPU_RUN 2'h0
`define CPU_WAIT 2'h1
`define CPU_STOP 2'h2
`define INIT_SYNC_STAGES 3
`endif

// ---- rtl/data_fifo.v ----
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module data_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk_in,
	input wire arst_n_in,
	input wire flush_in,
	input wire [WIDTH-1:0] wr_data_in,
	input wire wr_valid_in,
	output wire wr_ready_out,
	output reg [WIDTH-1:0] rd_data_out,
	output wire rd_valid_out,
	input wire rd_ready_in
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire do_wr;
	wire do_rd;
	assign wr_ready_out = (count != DEPTH[AW:0]);
	assign rd_valid_out = (count != {(AW+1){1'b0}});
	assign do_wr = wr_valid_in && wr_ready_out;
	assign do_rd = rd_valid_out && rd_ready_in;
	always @(posedge clk_in) begin
		if (do_wr)
			mem[wr_ptr] <= wr_data_in;
	end
	always @* begin
		rd_data_out = mem[rd_ptr];
	end
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else if (flush_in) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (do_wr)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (do_rd)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (do_wr && !do_rd)
				count <= count + 1'b1;
			else if (do_rd && !do_wr)
				count <= count - 1'b1;
		end
	end
endmodule // data_fifo
`default_nettype wire

// ---- testbench/can_mode_sva.sv ----
// assertions on the mode control ports
`timescale 1ns/1ps
`default_nettype none
module can_mode_sva (
	input wire logic CORE_CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic MODULE_ENABLE_BIT_IN,
	input wire logic SLEEP_REQUEST_BIT_IN,
	input wire logic STOP_IN_WAIT_BIT_IN,
	input wire logic [1:0] CPU_MODE_IN,
	input wire logic SPECIAL_MODE_IN,
	input wire logic LISTEN_ONLY_IN,
	input wire logic CFG_WRITE_IN,
	input wire logic TX_PENDING_IN,
	input wire logic PROTO_DOMINANT_IN,
	input wire logic BUS_TRANSMIT_PIN_OUT,
	input wire logic MONITOR_BIT_OUT,
	input wire logic INIT_ACKNOWLEDGE_FLAG_OUT,
	input wire logic SLEEP_ACKNOWLEDGE_FLAG_OUT,
	input wire logic INIT_REQUEST_STATE_OUT,
	input wire logic CONFIG_LOCKED_OUT,
	input wire logic REGS_RESET_OUT,
	input wire logic ENGINE_RUN_OUT,
	input wire logic REG_CLOCK_RUN_OUT,
	input wire logic POWER_DOWN_OUT,
	input wire logic [3:0] SEGMENT1_FIELD_OUT,
	input wire logic SAMPLE_POINT_OUT
);
	wire rq = INIT_REQUEST_STATE_OUT;
	wire ia = INIT_ACKNOWLEDGE_FLAG_OUT;
	wire pd = POWER_DOWN_OUT;
	wire run = ENGINE_RUN_OUT;
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	AST_ACK_DELAY: assert property ($rose(rq) && !pd |-> ##4 ia)
		else $error("init ack timing");
	AST_ACK_CAUSE: assert property ($rose(ia) |-> rq)
		else $error("ack without request");
	AST_REQ_HOLD: assert property (rq && !ia && MODULE_ENABLE_BIT_IN |=> rq)
		else $error("request cleared early");
	AST_ENABLE_INIT: assert property ($rose(MODULE_ENABLE_BIT_IN) |=> rq)
		else $error("enable skipped init");
	AST_INIT_TX: assert property (rq |=> BUS_TRANSMIT_PIN_OUT)
		else $error("dominant in init");
	AST_SAMPLE_RUN: assert property (SAMPLE_POINT_OUT |-> run)
		else $error("sample point while stopped");
	AST_INIT_STOP: assert property (rq |-> !run)
		else $error("engine runs in init");
	AST_LISTEN: assert property (LISTEN_ONLY_IN && $past(LISTEN_ONLY_IN) |-> BUS_TRANSMIT_PIN_OUT)
		else $error("listen only drove bus");
	AST_LOOPBACK: assert property (LISTEN_ONLY_IN && PROTO_DOMINANT_IN && run |-> !MONITOR_BIT_OUT)
		else $error("dominant not looped back");
	AST_LOCK: assert property (CONFIG_LOCKED_OUT == !(SPECIAL_MODE_IN || REGS_RESET_OUT))
		else $error("lock state wrong");
	AST_WRITE_REFUSED: assert property (CFG_WRITE_IN && CONFIG_LOCKED_OUT |=> $stable(SEGMENT1_FIELD_OUT))
		else $error("locked write taken");
	AST_REGS_RESET: assert property (REGS_RESET_OUT == (rq && ia))
		else $error("register reset wrong");
	AST_POWER_MODE: assert property (MODULE_ENABLE_BIT_IN |-> pd == (CPU_MODE_IN == 2'h2
		|| (CPU_MODE_IN == 2'h1 && STOP_IN_WAIT_BIT_IN))) else $error("power mode wrong");
	AST_CLOCKS_OFF: assert property (pd || !MODULE_ENABLE_BIT_IN |-> !run && (!pd || !REG_CLOCK_RUN_OUT))
		else $error("clock running");
	AST_SLEEP_ACK: assert property ($rose(SLEEP_ACKNOWLEDGE_FLAG_OUT) |-> $past(SLEEP_REQUEST_BIT_IN)
		&& !$past(TX_PENDING_IN)) else $error("sleep ack early");
endmodule // can_mode_sva
bind can_bit_timing_mode_control can_mode_sva sva (.*);
`default_nettype wire

// ---- testbench/bus_node.sv ----
// far bus node wired with the transmit pin
`timescale 1ns/1ps
`default_nettype none
module bus_node #(
	parameter int BIT_CLOCKS = 14
) (
	input wire logic clk_in,
	input wire logic tx_pin_in,
	output logic rx_pin_out
);
	logic drive = 1'b1;
	// dominant wins, recessive when idle
	assign rx_pin_out = tx_pin_in & drive;
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			drive <= b[i];
			repeat (BIT_CLOCKS) @(posedge clk_in);
		end
	endtask
endmodule // bus_node
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the mode control block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic CORE_CLK_IN = 0, ARST_N_IN = 0, MODULE_ENABLE_BIT_IN = 0, INIT_REQUEST_BIT_IN = 0;
	logic SLEEP_REQUEST_BIT_IN = 0, STOP_IN_WAIT_BIT_IN = 0, SPECIAL_MODE_IN = 0;
	logic LISTEN_ONLY_IN = 0, TRIPLE_SAMPLE_IN = 0, CFG_WRITE_IN = 0, TX_PENDING_IN = 0;
	logic TX_VALID_IN = 0, PROTO_DOMINANT_IN = 0, RX_READY_IN = 0, s, open = 0;
	logic [1:0] CPU_MODE_IN = 0, CFG_JUMP_WIDTH_FIELD_IN = 0;
	logic [5:0] CFG_PRESCALE_IN = 0;
	logic [3:0] CFG_SEGMENT1_FIELD_IN = 0;
	logic [2:0] CFG_SEGMENT2_FIELD_IN = 0;
	logic [7:0] TX_DATA_IN = 0, q[$];
	logic [8:0] m = {4'h3, 3'h1, 2'h0};
	logic [15:0] lfsr = 16'h5975;
	wire TX_READY_OUT, BUS_RECEIVE_PIN_IN, BUS_TRANSMIT_PIN_OUT, RX_VALID_OUT, MONITOR_BIT_OUT;
	wire INIT_ACKNOWLEDGE_FLAG_OUT, SLEEP_ACKNOWLEDGE_FLAG_OUT, INIT_REQUEST_STATE_OUT;
	wire CONFIG_LOCKED_OUT, REGS_RESET_OUT, ENGINE_RUN_OUT, REG_CLOCK_RUN_OUT, POWER_DOWN_OUT;
	wire SAMPLE_POINT_OUT;
	wire [7:0] RX_DATA_OUT;
	wire [3:0] SEGMENT1_FIELD_OUT;
	wire [2:0] SEGMENT2_FIELD_OUT;
	wire [1:0] JUMP_WIDTH_FIELD_OUT;
	int errors = 0, comparisons = 0, n;
	can_bit_timing_mode_control dut (.*);
	bus_node #(.BIT_CLOCKS(14)) node (.clk_in(CORE_CLK_IN), .tx_pin_in(BUS_TRANSMIT_PIN_OUT),
		.rx_pin_out(BUS_RECEIVE_PIN_IN));
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		if (errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	function automatic logic fl(input int k);
		logic [1:0] f;
		f = {SLEEP_ACKNOWLEDGE_FLAG_OUT, INIT_ACKNOWLEDGE_FLAG_OUT};
		return f[k];
	endfunction
	// bounded wait, leaves at a falling edge
	task automatic wt(input int k, input logic v);
		n = 0;
		do begin
			@(negedge CORE_CLK_IN);
			n++;
		end while (fl(k) !== v && n < 2000);
	endtask
	// timing write, model keeps fields only while unlocked
	task automatic cfg(input logic [5:0] p, input logic [3:0] a, input logic [2:0] b,
		input logic [1:0] j);
		@(posedge CORE_CLK_IN);
		{CFG_PRESCALE_IN, CFG_SEGMENT1_FIELD_IN, CFG_SEGMENT2_FIELD_IN} <= {p, a, b};
		{CFG_JUMP_WIDTH_FIELD_IN, CFG_WRITE_IN} <= {j, 1'b1};
		@(posedge CORE_CLK_IN) CFG_WRITE_IN <= 0;
		@(negedge CORE_CLK_IN);
		if (open)
			m = {a < 4'h3 ? 4'h3 : a, b == 3'h0 ? 3'h1 : b, j};
		chk({SEGMENT1_FIELD_OUT, SEGMENT2_FIELD_OUT, JUMP_WIDTH_FIELD_OUT}, m);
		chk(CONFIG_LOCKED_OUT, !open);
	endtask
	initial forever #2 CORE_CLK_IN = ~CORE_CLK_IN;
	initial begin
		#200000;
		errors++;
		close_out();
	end
	initial begin
		repeat (5) @(posedge CORE_CLK_IN);
		ARST_N_IN <= 1;
		@(negedge CORE_CLK_IN);
		chk(ENGINE_RUN_OUT, 0);
		@(posedge CORE_CLK_IN) {MODULE_ENABLE_BIT_IN, INIT_REQUEST_BIT_IN} <= 2'h3;
		repeat (2) @(negedge CORE_CLK_IN);
		chk({INIT_REQUEST_STATE_OUT, INIT_ACKNOWLEDGE_FLAG_OUT, ENGINE_RUN_OUT}, 3'h4);
		wt(0, 1);
		chk({INIT_ACKNOWLEDGE_FLAG_OUT, REGS_RESET_OUT, ENGINE_RUN_OUT}, 3'h6);
		open = 1;
		for (int i = 0; i < 16; i++)
			cfg(6'(rnd()), 4'(i), 3'(i), 2'(rnd()));
		cfg(6'h00, 4'h4, 3'h1, 2'h1);
		@(posedge CORE_CLK_IN) INIT_REQUEST_BIT_IN <= 0;
		wt(0, 0);
		open = 0;
		cfg(6'h05, 4'h2, 3'h0, 2'h3);
		@(posedge CORE_CLK_IN) SPECIAL_MODE_IN <= 1;
		open = 1;
		cfg(6'h00, 4'h8, 3'h3, 2'h2);
		@(posedge CORE_CLK_IN);
		{SPECIAL_MODE_IN, LISTEN_ONLY_IN, TRIPLE_SAMPLE_IN, PROTO_DOMINANT_IN} <= 4'h7;
		@(negedge CORE_CLK_IN);
		chk({MONITOR_BIT_OUT, BUS_TRANSMIT_PIN_OUT}, 2'h1);
		@(posedge CORE_CLK_IN) {PROTO_DOMINANT_IN, TX_VALID_IN} <= 2'h1;
		n = 0;
		repeat (12) begin
			@(posedge CORE_CLK_IN);
			if (TX_READY_OUT === 1'b1)
				n++;
			TX_DATA_IN <= rnd();
		end
		TX_VALID_IN <= 0;
		chk(16'(n), 8);
		repeat (300) @(posedge CORE_CLK_IN);
		repeat (8) begin
			q.push_back(rnd() & 8'h7F | 8'h01);
			node.send(q[$]);
		end
		repeat (300) @(posedge CORE_CLK_IN);
		RX_READY_IN <= 1;
		repeat (20) begin
			@(posedge CORE_CLK_IN);
			if (RX_VALID_OUT === 1'b1 && q.size() > 0)
				chk(RX_DATA_OUT, q.pop_front());
		end
		chk(16'(q.size()), 0);
		@(posedge CORE_CLK_IN) {LISTEN_ONLY_IN, SLEEP_REQUEST_BIT_IN} <= 2'h1;
		repeat (2) @(negedge CORE_CLK_IN);
		chk(SLEEP_ACKNOWLEDGE_FLAG_OUT, 0);
		n = 0;
		while (BUS_TRANSMIT_PIN_OUT !== 1'b0 && n < 20) begin
			@(negedge CORE_CLK_IN);
			n++;
		end
		chk(BUS_TRANSMIT_PIN_OUT, 0);
		@(posedge CORE_CLK_IN) TX_PENDING_IN <= 1;
		repeat (1500) @(negedge CORE_CLK_IN);
		chk(SLEEP_ACKNOWLEDGE_FLAG_OUT, 0);
		@(posedge CORE_CLK_IN) TX_PENDING_IN <= 0;
		wt(1, 1);
		chk({TX_READY_OUT, ENGINE_RUN_OUT, REG_CLOCK_RUN_OUT}, 3'h5);
		@(posedge CORE_CLK_IN) INIT_REQUEST_BIT_IN <= 1;
		@(posedge CORE_CLK_IN) INIT_REQUEST_BIT_IN <= 0;
		@(negedge CORE_CLK_IN);
		chk({INIT_REQUEST_STATE_OUT, INIT_ACKNOWLEDGE_FLAG_OUT}, 2'h2);
		wt(0, 1);
		wt(0, 0);
		chk(INIT_REQUEST_STATE_OUT, 0);
		@(posedge CORE_CLK_IN) SLEEP_REQUEST_BIT_IN <= 0;
		repeat (8) @(posedge CORE_CLK_IN);
		for (int i = 0; i < 8; i++) begin
			@(posedge CORE_CLK_IN) {CPU_MODE_IN, STOP_IN_WAIT_BIT_IN} <= 3'(i);
			@(negedge CORE_CLK_IN);
			s = i[2:1] == 2 || (i[2:1] == 1 && i[0]);
			chk({POWER_DOWN_OUT, ENGINE_RUN_OUT}, {s, !s});
		end
		@(posedge CORE_CLK_IN) MODULE_ENABLE_BIT_IN <= 0;
		@(negedge CORE_CLK_IN);
		chk(ENGINE_RUN_OUT, 0);
		close_out();
	end
endmodule // tb
`default_nettype wire
